/* File: hw/sbs_burst_ctr.sv */
// two-bit burst address counter, linear or interleaved order
module sbs_burst_ctr (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // control
  input  wire logic       load,
  input  wire logic [1:0] start,
  input  wire logic       step,
  input  wire logic       interleave,
  // results
  output logic      [1:0] cur_low,
  output logic      [1:0] next_low,
  output logic      [1:0] count
);

  logic [1:0] start_q;
  logic [1:0] cnt_q;
  logic [1:0] cnt_inc;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      start_q <= 2'h0;
      cnt_q   <= 2'h0;
    end else if (load) begin
      start_q <= start;
      cnt_q   <= 2'h0;
    end else if (step) begin
      // two bits wrap on their own: fifth word is the first again
      cnt_q   <= cnt_inc;
    end
  end

  assign cnt_inc = cnt_q + 2'h1;

  // interleave xors the count, linear adds it modulo four
  assign cur_low  = interleave ? (start_q ^ cnt_q)
                               : (start_q + cnt_q);
  assign next_low = interleave ? (start_q ^ cnt_inc)
                               : (start_q + cnt_inc);
  assign count    = cnt_q;

endmodule // sbs_burst_ctr

/* File: hw/sbs_pkg.sv */
// shared constants and carriers for the sync burst sram block
package sbs_pkg;

  // memory geometry
  localparam int ADDR_W   = 18;
  localparam int DATA_W   = 36;
  localparam int LANES    = 4;
  localparam int BURST_LEN = 4;

  // register offsets on the axi4-lite port
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;

  // control register fields
  localparam int CTRL_SLEEP_BIT = 0;
  localparam logic CTRL_SLEEP_RST = 1'h0;

  // status register fields
  localparam int ST_ASLEEP  = 0;
  localparam int ST_DRIVE   = 1;
  localparam int ST_BURST   = 2;
  localparam int ST_CNT_LO  = 4;
  localparam int ST_ORDER   = 6;
  localparam int ST_SINGLE  = 7;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // burst tracking state
  typedef enum logic {
    BST_DESEL,
    BST_ACTIVE
  } sbs_bstate_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [3:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [3:0]  araddr;
    logic        rready;
  } sbs_axi_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } sbs_axi_rsp_t;

endpackage

/* File: hw/sbs_sram.sv */
// pipelined sync burst sram core with axi4-lite control port
// Behaviour
// - 256K words of 36 bits each
// - sync inputs sampled on rising clock edge only
// - output enable and sleep act asynchronously
// - either address strobe loads burst start
// - two-bit counter supplies low address bits
// - counter advances only when step asserted
// - counter order linear or interleaved
// - order select low linear, high interleaved
// - counter wraps to start after four words
// - unconnected modes give interleaved pipelined operation
// - new address accepted every cycle, no stall
// - dual deselect pipelined like a read
// - single deselect one stage earlier than read
// - dual deselect holds one cycle then off
// - static mode pin picks single or dual
// - byte gate writes only enabled lanes
// - global write writes all four lanes
// - writes self-timed, no extra strobes
// - sleep on request high or control register sleep bit
// - contents kept intact through sleep
module sbs_sram #(
  parameter int ADDR_W = sbs_pkg::ADDR_W,
  parameter int DATA_W = sbs_pkg::DATA_W,
  parameter int LANES  = sbs_pkg::LANES
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // address and data
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   dq_in,
  output logic      [DATA_W-1:0]   dq_out,
  output logic                     dq_oe,
  // access strobes
  input  wire logic                chip_select_n,
  input  wire logic                processor_addr_strobe_n,
  input  wire logic                controller_addr_strobe_n,
  input  wire logic                burst_step_n,
  // write controls
  input  wire logic                byte_write_gate_n,
  input  wire logic [LANES-1:0]    lane_write_n,
  input  wire logic                all_bytes_write_n,
  // asynchronous controls
  input  wire logic                out_en_n,
  input  wire logic                sleep_request,
  // static mode pins
  input  wire logic                burst_order_sel,
  input  wire logic                deselect_mode_sel,
  // register port
  input  wire sbs_pkg::sbs_axi_req_t s_axi_req,
  output sbs_pkg::sbs_axi_rsp_t      s_axi_rsp
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH  = 1 << ADDR_W;

  // word size must split evenly into lanes, counter needs two bits
  if (DATA_W % LANES != 0 || ADDR_W < 2 || LANES < 1) begin : g_chk
    $error("sbs_sram: unsupported geometry");
  end

  // pins through two flops: bit 0 order, 1 single deselect, 2 sleep
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // reset values match the pull-up defaults of floating pins
      pin_meta_q <= 3'h3;
      pin_sync_q <= 3'h3;
    end else begin
      pin_meta_q <= {sleep_request, deselect_mode_sel, burst_order_sel};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic interleave;
  logic single_desel;

  assign interleave   = pin_sync_q[0];
  assign single_desel = pin_sync_q[1];

  // soft sleep from the control register
  logic soft_sleep_q;
  logic sleep_now;
  logic run;

  // raw pin gates sampling: the edge that sees it high takes nothing
  assign sleep_now = sleep_request | soft_sleep_q;
  assign run       = ~sleep_now;

  // command decode from the sampled pins
  logic             start_p;
  logic             start_c;
  logic             strobe;
  logic             begin_acc;
  logic             deselect;
  logic             wr_req;
  logic [LANES-1:0] lane_en;

  assign start_p   = ~processor_addr_strobe_n;
  assign start_c   = ~controller_addr_strobe_n;
  assign strobe    = start_p | start_c;
  assign begin_acc = strobe & ~chip_select_n;
  assign deselect  = strobe & chip_select_n;
  assign wr_req    = ~all_bytes_write_n |
                     (~byte_write_gate_n & ~(&lane_write_n));

  assign lane_en = !all_bytes_write_n ? {LANES{1'b1}} :
                   !byte_write_gate_n ? ~lane_write_n :
                                        {LANES{1'b0}};

  // burst tracking
  sbs_pkg::sbs_bstate_t bst_q;
  logic                 cont_acc;
  logic                 step;
  logic [1:0]           cur_low;
  logic [1:0]           next_low;
  logic [1:0]           burst_cnt;

  assign cont_acc = (bst_q == sbs_pkg::BST_ACTIVE) & ~strobe;
  assign step     = run & cont_acc & ~burst_step_n;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bst_q <= sbs_pkg::BST_DESEL;
    end else if (run) begin
      case (bst_q)
        sbs_pkg::BST_DESEL: begin
          if (begin_acc) bst_q <= sbs_pkg::BST_ACTIVE;
        end
        sbs_pkg::BST_ACTIVE: begin
          if (deselect) bst_q <= sbs_pkg::BST_DESEL;
        end
        default: begin
          bst_q <= sbs_pkg::BST_DESEL;
        end
      endcase
    end
  end

  sbs_burst_ctr u_ctr (
    .mclk       (mclk),
    .nrst       (nrst),
    .load       (run & begin_acc),
    .start      (addr[1:0]),
    .step       (step),
    .interleave (interleave),
    .cur_low    (cur_low),
    .next_low   (next_low),
    .count      (burst_cnt)
  );

  // upper address bits held for the burst
  logic [ADDR_W-1:2] upper_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      upper_q <= '0;
    end else if (run && begin_acc) begin
      upper_q <= addr[ADDR_W-1:2];
    end
  end

  // input stage: one access taken per edge, never stalls
  logic              cmd_rd_q;
  logic              cmd_wr_q;
  logic              cmd_des_q;
  logic [ADDR_W-1:0] acc_addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [LANES-1:0]  lanes_q;
  logic              acc_now;
  logic              acc_wr;
  logic [ADDR_W-1:0] acc_addr;

  assign acc_now = begin_acc | cont_acc;
  // a processor strobe start is always a read
  assign acc_wr  = wr_req & ~(start_p & begin_acc);

  assign acc_addr = begin_acc     ? addr :
                    !burst_step_n ? {upper_q, next_low} :
                                    {upper_q, cur_low};

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cmd_rd_q  <= 1'h0;
      cmd_wr_q  <= 1'h0;
      cmd_des_q <= 1'h0;
    end else begin
      // sampled only at the rising edge, nothing taken in sleep
      cmd_rd_q  <= run & acc_now & ~acc_wr;
      cmd_wr_q  <= run & acc_now & acc_wr;
      cmd_des_q <= run & deselect;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_addr_q <= '0;
      wdata_q    <= '0;
      lanes_q    <= '0;
    end else if (run && acc_now) begin
      acc_addr_q <= acc_addr;
      wdata_q    <= dq_in;
      lanes_q    <= lane_en;
    end
  end

  // one array per lane; written the edge after capture, no strobes
  logic [DATA_W-1:0] rd_word;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];

    // pending write finishes even if sleep arrives; array never reset
    always_ff @(posedge mclk) begin
      if (cmd_wr_q && lanes_q[l]) begin
        mem[acc_addr_q] <= wdata_q[l*LANE_W +: LANE_W];
      end
    end

    assign rd_word[l*LANE_W +: LANE_W] = mem[acc_addr_q];
  end

  // output register and deselect pipeline
  logic [DATA_W-1:0] rd_q;
  logic              out_on_q;
  logic              out_live;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= '0;
    end else if (cmd_rd_q) begin
      rd_q <= rd_word;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_on_q <= 1'h0;
    end else if (cmd_rd_q) begin
      out_on_q <= 1'h1;
    end else if (cmd_des_q || cmd_wr_q) begin
      // dual mode: off one edge after capture, same depth as a read
      out_on_q <= 1'h0;
    end
  end

  // single mode drops the drive as soon as deselect is captured
  assign out_live = out_on_q & ~(single_desel & cmd_des_q);

  // output enable and sleep pin gate the drive with no clock
  assign dq_oe  = out_live & ~out_en_n & ~sleep_request;
  assign dq_out = rd_q;

  // axi4-lite slave: address and data taken in either order
  logic        aw_have_q;
  logic        w_have_q;
  logic [3:0]  awaddr_q;
  logic [31:0] wdata_ax_q;
  logic [3:0]  wstrb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_take;
  logic        w_take;
  logic        ar_take;
  logic        do_write;
  logic [31:0] status;

  assign aw_take  = s_axi_req.awvalid & ~aw_have_q & ~bvalid_q;
  assign w_take   = s_axi_req.wvalid & ~w_have_q & ~bvalid_q;
  assign ar_take  = s_axi_req.arvalid & ~rvalid_q;
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      aw_have_q <= 1'h0;
      awaddr_q  <= 4'h0;
    end else if (aw_take) begin
      aw_have_q <= 1'h1;
      awaddr_q  <= s_axi_req.awaddr;
    end else if (do_write) begin
      aw_have_q <= 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      w_have_q   <= 1'h0;
      wdata_ax_q <= 32'h0;
      wstrb_q    <= 4'h0;
    end else if (w_take) begin
      w_have_q   <= 1'h1;
      wdata_ax_q <= s_axi_req.wdata;
      wstrb_q    <= s_axi_req.wstrb;
    end else if (do_write) begin
      w_have_q   <= 1'h0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q     <= 1'h0;
      bresp_q      <= sbs_pkg::RESP_OKAY;
      soft_sleep_q <= sbs_pkg::CTRL_SLEEP_RST;
    end else if (do_write) begin
      bvalid_q <= 1'h1;
      if (awaddr_q[3:2] == sbs_pkg::OFS_CTRL[3:2]) begin
        bresp_q <= sbs_pkg::RESP_OKAY;
        if (wstrb_q[0]) begin
          soft_sleep_q <= wdata_ax_q[sbs_pkg::CTRL_SLEEP_BIT];
        end
      end else begin
        // status is read only; other offsets are unmapped
        bresp_q <= sbs_pkg::RESP_SLVERR;
      end
    end else if (bvalid_q && s_axi_req.bready) begin
      bvalid_q <= 1'h0;
    end
  end

  always_comb begin
    status = 32'h0;
    status[sbs_pkg::ST_ASLEEP]    = pin_sync_q[2] | soft_sleep_q;
    status[sbs_pkg::ST_DRIVE]     = out_live;
    status[sbs_pkg::ST_BURST]     = bst_q == sbs_pkg::BST_ACTIVE;
    status[sbs_pkg::ST_CNT_LO+:2] = burst_cnt;
    status[sbs_pkg::ST_ORDER]     = interleave;
    status[sbs_pkg::ST_SINGLE]    = single_desel;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'h0;
      rdata_q  <= 32'h0;
      rresp_q  <= sbs_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'h1;
      if (s_axi_req.araddr[3:2] == sbs_pkg::OFS_CTRL[3:2]) begin
        rdata_q <= {31'h0, soft_sleep_q};
        rresp_q <= sbs_pkg::RESP_OKAY;
      end else if (s_axi_req.araddr[3:2] ==
                   sbs_pkg::OFS_STATUS[3:2]) begin
        rdata_q <= status;
        rresp_q <= sbs_pkg::RESP_OKAY;
      end else begin
        rdata_q <= 32'h0;
        rresp_q <= sbs_pkg::RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_req.rready) begin
      rvalid_q <= 1'h0;
    end
  end

  assign s_axi_rsp.awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_rsp.wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_rsp.bvalid  = bvalid_q;
  assign s_axi_rsp.bresp   = bresp_q;
  assign s_axi_rsp.arready = ~rvalid_q;
  assign s_axi_rsp.rvalid  = rvalid_q;
  assign s_axi_rsp.rdata   = rdata_q;
  assign s_axi_rsp.rresp   = rresp_q;

endmodule // sbs_sram

/* File: testbench/sbs_host_model.sv */
// host controller model driving the sram pin side
module sbs_host_model (
  // clock
  input  wire logic        mclk,
  // sram pins
  output logic      [17:0] addr,
  output logic      [35:0] dq_in,
  output logic             chip_select_n,
  output logic             processor_addr_strobe_n,
  output logic             controller_addr_strobe_n,
  output logic             burst_step_n,
  output logic             byte_write_gate_n,
  output logic      [3:0]  lane_write_n,
  output logic             all_bytes_write_n,
  // read sampled two edges back
  output logic             rd_due
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       rd_now;
  logic [1:0] rd_pipe;

  initial begin
    {addr, dq_in, lane_write_n} = '0;
    {chip_select_n, processor_addr_strobe_n, controller_addr_strobe_n} = 3'h7;
    {burst_step_n, byte_write_gate_n, all_bytes_write_n} = 3'h7;
    rd_now = 1'h0;
    rd_pipe = 2'h0;
  end

  assign rd_due = rd_pipe[1];
  always @(posedge mclk) rd_pipe <= {rd_pipe[0], rd_now};

  // k: 0 proc start, 1 ctrl start, 2 step, 3 hold, 4 deselect, 5 idle
  task automatic cmd(input int k, input logic [17:0] a, input logic [35:0] d,
                     input logic [1:0] w, input logic [3:0] ln);
    @(posedge mclk);
    // unused lines flip so a stale value never looks valid
    addr <= (k < 2) ? a : ~addr;
    dq_in <= (w != 2'h0) ? d : ~dq_in;
    processor_addr_strobe_n <= (k != 0);
    controller_addr_strobe_n <= !(k == 1 || k == 4);
    chip_select_n <= (k == 4);
    burst_step_n <= (k != 2);
    all_bytes_write_n <= (w != 2'h1);
    byte_write_gate_n <= (w != 2'h2);
    lane_write_n <= (w == 2'h2) ? ln : ~ln;
    rd_now <= (k < 4) && (k == 0 || w == 2'h0);
  endtask
endmodule // sbs_host_model

/* File: testbench/sbs_sram_assertions.sv */
// pin pipeline checks for the sync burst sram
module sbs_sram_assertions #(
  parameter int DATA_W = 36
) (
  // clock and reset
  input wire logic              mclk,
  input wire logic              nrst,
  // outputs
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic              dq_oe,
  // sampled pins
  input wire logic              chip_select_n,
  input wire logic              processor_addr_strobe_n,
  input wire logic              controller_addr_strobe_n,
  input wire logic              burst_step_n,
  input wire logic              byte_write_gate_n,
  input wire logic              all_bytes_write_n,
  // async and mode pins
  input wire logic              out_en_n,
  input wire logic              sleep_request,
  input wire logic              deselect_mode_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic nowr, ps, cs, p_rd, c_rd, hold, desel, off;
  // lane pattern ignored: a gate with no lane counts as write, fewer checks
  assign nowr  = all_bytes_write_n && byte_write_gate_n;
  assign ps    = !processor_addr_strobe_n;
  assign cs    = !controller_addr_strobe_n;
  assign p_rd  = !sleep_request && !chip_select_n && ps;
  assign c_rd  = !sleep_request && !chip_select_n && !ps && cs && nowr;
  assign hold  = !sleep_request && !ps && !cs && nowr;
  assign desel = !sleep_request && chip_select_n && (ps || cs);
  assign off   = out_en_n || sleep_request;

  AST_OE_GATED: assert property (out_en_n |-> !dq_oe)
    else $error("outputs driven with enable off");
  AST_SLEEP_QUIET: assert property (sleep_request |-> !dq_oe)
    else $error("outputs driven in sleep");
  AST_SLEEP_HELD: assert property (
    sleep_request [*3] |-> $stable(dq_out))
    else $error("read data moved in sleep");
  AST_READ_PIPE: assert property (
    p_rd ##1 hold |=> dq_oe || off)
    else $error("read data not driven one edge later");
  AST_CTRL_READ: assert property (
    c_rd ##1 (hold || p_rd || c_rd) |-> ##1 (dq_oe || off))
    else $error("second strobe read not driven");
  AST_STEP_HOLD: assert property (
    p_rd ##1 (hold && burst_step_n) |=> ##1 $stable(dq_out))
    else $error("burst moved without step");
  AST_SINGLE_OFF: assert property (
    deselect_mode_sel [*3] ##0 desel |=> !dq_oe)
    else $error("single deselect did not turn off");
  // a write just before the deselect drops the drive on its own
  AST_DUAL_OFF: assert property (
    (!deselect_mode_sel) [*3] ##0 (p_rd || c_rd || hold)
    ##1 (desel && dq_oe && !off) |=> (dq_oe || off) ##1 !dq_oe)
    else $error("dual deselect timing wrong");

  cover property (p_rd ##1 hold);
  cover property (deselect_mode_sel [*3] ##0 (desel && dq_oe));
  cover property ((!deselect_mode_sel) [*3] ##0 (p_rd || c_rd || hold)
    ##1 (desel && dq_oe));
  cover property (p_rd ##1 (hold && burst_step_n));
endmodule // sbs_sram_assertions

bind sbs_sram sbs_sram_assertions #(.DATA_W(DATA_W)) u_chk (
  .mclk, .nrst, .dq_out, .dq_oe, .chip_select_n, .processor_addr_strobe_n,
  .controller_addr_strobe_n, .burst_step_n, .byte_write_gate_n,
  .all_bytes_write_n, .out_en_n, .sleep_request, .deselect_mode_sel
);

/* File: testbench/sync_burst_sram_control_bench.sv */
// self-checking bench for the sync burst sram block
module sync_burst_sram_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk, nrst, out_en_n, sleep_request, rd_due;
  logic                  burst_order_sel, deselect_mode_sel, dq_oe;
  logic                  chip_select_n, processor_addr_strobe_n;
  logic                  controller_addr_strobe_n, burst_step_n;
  logic                  byte_write_gate_n, all_bytes_write_n;
  logic [3:0]            lane_write_n;
  logic [17:0]           addr, a;
  logic [17:0]           ab [8];
  logic [35:0]           dq_in, dq_out, d;
  logic [35:0]           mem [logic [17:0]];
  logic [37:0]           exp_q [$];
  sbs_pkg::sbs_axi_req_t s_axi_req;
  sbs_pkg::sbs_axi_rsp_t s_axi_rsp;
  int                    err_total = 0;
  int                    check_count = 0;
  int                    cycles = 0;

  sbs_sram uut (.mclk, .nrst, .addr, .dq_in, .dq_out, .dq_oe, .chip_select_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
    .byte_write_gate_n, .lane_write_n, .all_bytes_write_n, .out_en_n,
    .sleep_request, .burst_order_sel, .deselect_mode_sel, .s_axi_req,
    .s_axi_rsp);
  sbs_host_model host (.mclk, .addr, .dq_in, .chip_select_n,
    .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_step_n,
    .byte_write_gate_n, .lane_write_n, .all_bytes_write_n, .rd_due);

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [37:0] v, input logic [37:0] e,
                     input string nm);
    check_count++;
    if (v !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, v);
    end
  endtask

  task automatic see(input logic [37:0] v, input string nm);
    logic [37:0] e;
    // an unexpected result must fail even when it is unknown
    e = (exp_q.size() > 0) ? exp_q.pop_front() : {38{1'bz}};
    chk(v, e, nm);
  endtask

  always @(posedge mclk) begin
    if (rd_due === 1'h1) see({2'h0, dq_out}, "dq_out");
    if ((s_axi_rsp.rvalid & s_axi_req.rready) === 1'h1)
      see({s_axi_rsp.rresp, 4'h0, s_axi_rsp.rdata}, "rdata");
    if ((s_axi_rsp.bvalid & s_axi_req.bready) === 1'h1)
      see({s_axi_rsp.bresp, 36'h0}, "bresp");
  end

  task automatic wrap_up();
    if (exp_q.size() != 0) err_total++;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic axi_wr(input logic [3:0] x, input logic [31:0] v,
                        input logic [1:0] er);
    @(posedge mclk);
    exp_q.push_back({er, 36'h0});
    s_axi_req.awvalid <= 1'h1;
    s_axi_req.awaddr <= x;
    s_axi_req.wvalid <= 1'h1;
    s_axi_req.wdata <= v;
    s_axi_req.wstrb <= 4'hf;
    s_axi_req.bready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_rsp.awready === 1'h1) s_axi_req.awvalid <= 1'h0;
      if (s_axi_rsp.wready === 1'h1) s_axi_req.wvalid <= 1'h0;
    end while (s_axi_rsp.bvalid !== 1'h1);
    s_axi_req.bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [3:0] x, input logic [31:0] e,
                        input logic [1:0] er);
    @(posedge mclk);
    exp_q.push_back({er, 4'h0, e});
    s_axi_req.arvalid <= 1'h1;
    s_axi_req.araddr <= x;
    s_axi_req.rready <= 1'h1;
    do begin
      @(posedge mclk);
      if (s_axi_rsp.arready === 1'h1) s_axi_req.arvalid <= 1'h0;
    end while (s_axi_rsp.rvalid !== 1'h1);
    s_axi_req.rready <= 1'h0;
  endtask

  // write start on the second strobe; expected image updated per lane
  task automatic wr(input logic [17:0] x, input logic [35:0] v,
                    input logic [1:0] w, input logic [3:0] ln);
    for (int l = 0; l < 4; l++)
      if (w == 2'h1 || !ln[l]) mem[x][9*l +: 9] = v[9*l +: 9];
    host.cmd(1, x, v, w, ln);
  endtask

  task automatic rd(input int k, input logic [17:0] x);
    exp_q.push_back({2'h0, mem[x]});
    host.cmd(k, x, '0, 2'h0, 4'h0);
  endtask

  function automatic logic [17:0] at(input logic [17:0] b,
                                     input logic [1:0] n, input logic o);
    return {b[17:2], o ? b[1:0] ^ n : b[1:0] + n};
  endfunction

  initial begin
    nrst = 1'h0;
    out_en_n = 1'h0;
    sleep_request = 1'h0;
    burst_order_sel = 1'h1;
    deselect_mode_sel = 1'h1;
    s_axi_req = '0;
    void'($urandom(32'hf447fe73));
    repeat (3) @(posedge mclk);
    nrst <= 1'h1;
    axi_rd(sbs_pkg::OFS_CTRL, 32'h0, sbs_pkg::RESP_OKAY);
    axi_rd(4'h8, 32'h0, sbs_pkg::RESP_SLVERR);
    axi_rd(sbs_pkg::OFS_STATUS, 32'h1 << sbs_pkg::ST_ORDER |
           32'h1 << sbs_pkg::ST_SINGLE, sbs_pkg::RESP_OKAY);
    axi_wr(sbs_pkg::OFS_STATUS, 32'h0, sbs_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      ab[i] = 18'($urandom);
      wr(ab[i], {4'($urandom), $urandom}, 2'h1, 4'h0);
    end
    for (int i = 0; i < 8; i++)
      wr(ab[i], {4'($urandom), $urandom}, 2'h2, 4'($urandom));
    for (int i = 0; i < 8; i++) begin
      out_en_n <= 1'($urandom);
      rd(i % 2, ab[i]);
    end
    host.cmd(4, '0, '0, 2'h0, 4'h0);
    out_en_n <= 1'h0;
    $display("test writes done");
    for (int o = 0; o < 2; o++) begin
      burst_order_sel <= o[0];
      deselect_mode_sel <= o[0];
      a = 18'($urandom);
      for (int n = 0; n < 4; n++)
        wr(at(a, 2'(n), 1'h0), {4'($urandom), $urandom}, 2'h1, 4'h0);
      rd(0, a);
      rd(3, a);
      rd(2, at(a, 2'h1, o[0]));
      rd(3, at(a, 2'h1, o[0]));
      rd(2, at(a, 2'h2, o[0]));
      rd(2, at(a, 2'h3, o[0]));
      rd(2, a);
      host.cmd(4, '0, '0, 2'h0, 4'h0);
      $display("test burst order %0d done", o);
    end
    for (int s = 0; s < 2; s++) begin
      a = 18'($urandom);
      d = {4'($urandom), $urandom};
      wr(a, d, 2'h1, 4'h0);
      host.cmd(4, '0, '0, 2'h0, 4'h0);
      if (s == 0) sleep_request <= 1'h1;
      else axi_wr(sbs_pkg::OFS_CTRL, 32'h1, sbs_pkg::RESP_OKAY);
      if (s == 1) axi_rd(sbs_pkg::OFS_CTRL, 32'h1, sbs_pkg::RESP_OKAY);
      host.cmd(1, a, ~d, 2'h1, 4'h0);
      #1;
      if (s == 0) chk(38'(dq_oe), 38'h0, "dq_oe");
      repeat (2) host.cmd(4, '0, '0, 2'h0, 4'h0);
      if (s == 0) sleep_request <= 1'h0;
      else axi_wr(sbs_pkg::OFS_CTRL, 32'h0, sbs_pkg::RESP_OKAY);
      rd(0, a);
      host.cmd(4, '0, '0, 2'h0, 4'h0);
      $display("test sleep source %0d done", s);
    end
    repeat (3) host.cmd(5, '0, '0, 2'h0, 4'h0);
    wrap_up();
  end
endmodule // sync_burst_sram_control_bench
